// *** shared/threshold_pkg.sv ***
package threshold_pkg;
  // command codes of the threshold registers
  localparam logic [7:0] CMD_FLOOR = 8'h2B;
  localparam logic [7:0] CMD_START = 8'h35;
  localparam logic [7:0] CMD_STOP = 8'h36;
  // reset words
  localparam logic [15:0] FLOOR_RST = 16'h00B3;
  localparam logic [15:0] START_RST = 16'hF012;
  localparam logic [15:0] STOP_RST = 16'hF010;
  // floor field layout: fixed exponent -9, writable mantissa 11:0
  localparam logic [4:0] FLOOR_EXP = 5'h17;
  localparam int FLOOR_MANT_W = 12;
  // floor range at loop scale one and one half
  localparam logic [15:0] FLOOR_MIN_FULL = 16'h00B3;
  localparam logic [15:0] FLOOR_MAX_FULL = 16'h0300;
  localparam logic [15:0] FLOOR_MIN_HALF = 16'h0166;
  localparam logic [15:0] FLOOR_MAX_HALF = 16'h0600;
  // input thresholds: exponent -2, fixed upper mantissa, 4-bit field
  localparam logic [4:0] QTR_EXP = 5'h1E;
  localparam logic [6:0] QTR_MANT_HI = 7'h01;
  localparam int QTR_NIB_W = 4;
  localparam logic [3:0] START_NIB_RST = 4'h2;
  localparam logic [3:0] STOP_NIB_RST = 4'h0;
  localparam logic [15:0] START_MIN = 16'h0011;
  localparam logic [15:0] START_MAX = 16'h001F;
  localparam logic [15:0] STOP_MIN = 16'h0010;
  localparam logic [15:0] STOP_MAX = 16'h001E;
  // shift that turns a linear word into quarter-volt counts
  localparam int QTR_SHIFT = 2;
  localparam int QTR_SHIFT_CAP = 12;
endpackage : threshold_pkg

// *** verilog/quarter_round.sv ***
`timescale 1ns/1ps
`default_nettype none
// converts a linear word into quarter-volt counts, round half up
module quarter_round (
  input wire logic [15:0] word_i, // linear word, exponent in 15:11
  output logic [15:0] code_o // counts, saturated to 0..FFFF
);
  import threshold_pkg::*;

  logic signed [31:0] mant;
  logic signed [31:0] res;
  int k;
  int s;

  // scale mantissa by two to the exponent plus two
  always_comb begin
    mant = 32'($signed(word_i[10:0]));
    k = int'($signed(word_i[15:11])) + QTR_SHIFT;
    s = 0;
    res = '0;
    if (k >= 0) begin
      if (k > QTR_SHIFT_CAP) begin
        res = (mant < 0) ? -32'sd1 : ((mant == 0) ? 32'sd0 : 32'sh0001_0000);
      end else begin
        res = mant <<< k;
      end
    end else begin
      s = -k;
      res = (mant + (32'sd1 <<< (s - 1))) >>> s;
    end
    if (res < 0) begin
      code_o = 16'h0000;
    end else if (res > 32'sh0000_FFFF) begin
      code_o = 16'hFFFF;
    end else begin
      code_o = res[15:0];
    end
  end
endmodule : quarter_round
`default_nettype wire

// *** verilog/threshold_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The output floor is an unsigned mantissa read with a fixed exponent of minus nine.
// - At loop scale one the floor starts at 179 and takes only 179 to 768.
// - At loop scale one half the floor starts at 358 and takes only 358 to 1536.
// - The run output rises once the input reaches the start threshold and start is allowed.
// - The run output falls once the input drops to the stop threshold.
// - A threshold write is rounded to the nearest quarter volt before storing.
// - Both input thresholds carry the fixed exponent 11110, a quarter volt per count.
// - The start threshold takes counts 17 to 31.
// - The start threshold resets to 18.
// - The stop threshold resets to 16 and takes counts 16 to 30.
// - Only the low four mantissa bits of the thresholds are stored.
// - A bad start write keeps the old value and raises cml, invalid data and alert.
// - A bad stop write keeps the old value and raises cml, invalid data and alert.
// - Start stays above stop; a write breaking that order is refused and flagged.
// - A store-all command copies both thresholds to the nonvolatile port.
// - With the output on, a reference below the floor is clamped and warned.
module threshold_regs (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic ce_i, // clock enable
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] cmd_i, // command code
  input wire logic [15:0] wdata_i, // write word
  input wire logic loop_half_i, // loop_scale_ratio is one half
  input wire logic clr_status_i, // clear status flags
  input wire logic store_all_i, // store-all-defaults command
  input wire logic [15:0] vin_code_i, // input voltage, quarter volts
  input wire logic start_ok_i, // other start conditions met
  input wire logic out_on_i, // output is on
  input wire logic vref_req_i, // new reference request
  input wire logic [15:0] vref_target_i, // requested reference counts
  output logic [15:0] rdata_o, // read word
  output logic rvalid_o, // read word valid
  output logic cml_o, // communication error summary
  output logic ivd_o, // invalid data
  output logic warn_o, // floor clamp warning
  output logic alert_o, // alert line, high active
  output logic run_o, // converter enabled
  output logic [15:0] vref_o, // reference after clamp
  output logic nvm_we_o, // nonvolatile write pulse
  output logic [15:0] nvm_start_o, // start word to store
  output logic [15:0] nvm_stop_o // stop word to store
);
  import threshold_pkg::*;

  logic [3:0] start_nib_q;
  logic [3:0] stop_nib_q;
  logic [15:0] floor_q;
  logic init_q;
  logic cml_q;
  logic ivd_q;
  logic warn_q;
  logic alert_q;
  logic run_q;
  logic [15:0] vref_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic nvm_we_q;
  logic [15:0] nvm_start_q;
  logic [15:0] nvm_stop_q;
  logic [15:0] wr_code;
  logic [15:0] start_code;
  logic [15:0] stop_code;
  logic [15:0] floor_lo;
  logic [15:0] floor_hi;
  logic wr_start;
  logic wr_stop;
  logic wr_floor;
  logic ok_start;
  logic ok_stop;
  logic ok_floor;
  logic reject;
  logic clamp;

  // threshold word from its stored nibble
  function automatic logic [15:0] qtr_word(input logic [3:0] nib);
    qtr_word = {QTR_EXP, QTR_MANT_HI, nib};
  endfunction : qtr_word

  // range test used by every register
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // rounding of the written word to quarter-volt counts
  quarter_round u_round (
    .word_i(wdata_i),
    .code_o(wr_code)
  );

  // whole-word validation ahead of any update
  always_comb begin
    start_code = 16'(qtr_word(start_nib_q)) & 16'h07FF;
    stop_code = 16'(qtr_word(stop_nib_q)) & 16'h07FF;
    floor_lo = loop_half_i ? FLOOR_MIN_HALF : FLOOR_MIN_FULL;
    floor_hi = loop_half_i ? FLOOR_MAX_HALF : FLOOR_MAX_FULL;
    wr_start = ce_i && wr_i && (cmd_i == CMD_START);
    wr_stop = ce_i && wr_i && (cmd_i == CMD_STOP);
    wr_floor = ce_i && wr_i && (cmd_i == CMD_FLOOR);
    ok_start = in_range(wr_code, START_MIN, START_MAX)
               && (wr_code > stop_code);
    ok_stop = in_range(wr_code, STOP_MIN, STOP_MAX)
              && (wr_code < start_code);
    ok_floor = in_range(wdata_i, floor_lo, floor_hi);
    reject = (wr_start && !ok_start) || (wr_stop && !ok_stop)
             || (wr_floor && !ok_floor);
    clamp = ce_i && vref_req_i && out_on_i && (vref_target_i < floor_q);
  end

  // start threshold nibble
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_nib_q <= START_NIB_RST;
    end else if (wr_start && ok_start) begin
      start_nib_q <= wr_code[3:0];
    end
  end

  // stop threshold nibble
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_nib_q <= STOP_NIB_RST;
    end else if (wr_stop && ok_stop) begin
      stop_nib_q <= wr_code[3:0];
    end
  end

  // floor: scale-dependent default caught after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      floor_q <= FLOOR_RST;
      init_q <= 1'b0;
    end else if (ce_i && !init_q) begin
      floor_q <= floor_lo;
      init_q <= 1'b1;
    end else if (wr_floor && ok_floor) begin
      floor_q <= wdata_i;
    end
  end

  // communication error flags, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cml_q <= 1'b0;
      ivd_q <= 1'b0;
    end else if (ce_i) begin
      if (reject) begin
        cml_q <= 1'b1;
        ivd_q <= 1'b1;
      end else if (clr_status_i) begin
        cml_q <= 1'b0;
        ivd_q <= 1'b0;
      end
    end
  end

  // floor clamp warning, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_q <= 1'b0;
    end else if (ce_i) begin
      if (clamp) begin
        warn_q <= 1'b1;
      end else if (clr_status_i) begin
        warn_q <= 1'b0;
      end
    end
  end

  // alert line follows any flagged event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_q <= 1'b0;
    end else if (ce_i) begin
      if (reject || clamp) begin
        alert_q <= 1'b1;
      end else if (clr_status_i) begin
        alert_q <= 1'b0;
      end
    end
  end

  // run control with start/stop hysteresis
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (ce_i) begin
      if (!run_q && start_ok_i && (vin_code_i >= start_code)) begin
        run_q <= 1'b1;
      end else if (run_q && (vin_code_i <= stop_code)) begin
        run_q <= 1'b0;
      end
    end
  end

  // reference with floor clamp
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vref_q <= FLOOR_RST;
    end else if (ce_i && vref_req_i) begin
      vref_q <= clamp ? floor_q : vref_target_i;
    end
  end

  // register read port, unmapped codes read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rvalid_q <= rd_i;
      if (rd_i) begin
        unique case (cmd_i)
          CMD_START: rdata_q <= qtr_word(start_nib_q);
          CMD_STOP: rdata_q <= qtr_word(stop_nib_q);
          CMD_FLOOR: rdata_q <= floor_q;
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // copy to nonvolatile storage on store-all
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_we_q <= 1'b0;
      nvm_start_q <= START_RST;
      nvm_stop_q <= STOP_RST;
    end else if (ce_i) begin
      nvm_we_q <= store_all_i;
      if (store_all_i) begin
        nvm_start_q <= qtr_word(start_nib_q);
        nvm_stop_q <= qtr_word(stop_nib_q);
      end
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign cml_o = cml_q;
  assign ivd_o = ivd_q;
  assign warn_o = warn_q;
  assign alert_o = alert_q;
  assign run_o = run_q;
  assign vref_o = vref_q;
  assign nvm_we_o = nvm_we_q;
  assign nvm_start_o = nvm_start_q;
  assign nvm_stop_o = nvm_stop_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence bad_start_s;
    wr_start && !ok_start;
  endsequence
  sequence bad_stop_s;
    wr_stop && !ok_stop;
  endsequence
  sequence low_ref_s;
    ce_i && vref_req_i && out_on_i && (vref_target_i < floor_q);
  endsequence
  sequence flags_up_s;
    cml_q && ivd_q && alert_q;
  endsequence

  floor_full_hold_a: assert property (
    (init_q && wr_floor && !loop_half_i
      && !in_range(wdata_i, FLOOR_MIN_FULL, FLOOR_MAX_FULL))
    |=> $stable(floor_q) && cml_q)
    else $error("floor took an out-of-range word at scale one");
  floor_half_take_a: assert property (
    (init_q && wr_floor && loop_half_i
      && in_range(wdata_i, FLOOR_MIN_HALF, FLOOR_MAX_HALF))
    |=> floor_q == $past(wdata_i))
    else $error("floor missed a valid word at scale one half");
  start_reject_a: assert property (
    bad_start_s |=> $stable(start_nib_q) ##0 flags_up_s)
    else $error("bad start write not refused and flagged");
  stop_reject_a: assert property (
    bad_stop_s |=> $stable(stop_nib_q) ##0 flags_up_s)
    else $error("bad stop write not refused and flagged");
  order_keep_a: assert property (
    start_code > stop_code)
    else $error("start threshold not above stop threshold");
  start_range_a: assert property (
    wr_start && ok_start |=> start_code == $past(wr_code)
      && in_range(start_code, START_MIN, START_MAX))
    else $error("accepted start write stored wrong");
  run_rise_a: assert property (
    ce_i && !run_q && start_ok_i && (vin_code_i >= start_code) |=> run_q)
    else $error("run did not rise at start threshold");
  run_fall_a: assert property (
    ce_i && run_q && (vin_code_i <= stop_code) |=> !run_q)
    else $error("run did not fall at stop threshold");
  nvm_copy_a: assert property (
    ce_i && store_all_i |=> nvm_we_o
      && nvm_start_o == qtr_word($past(start_nib_q))
      && nvm_stop_o == qtr_word($past(stop_nib_q)))
    else $error("store-all copy wrong");
  ref_clamp_a: assert property (
    low_ref_s |=> vref_q == $past(floor_q) && warn_q && alert_q)
    else $error("low reference not clamped and warned");
  start_read_a: assert property (
    ce_i && rd_i && cmd_i == CMD_START
    |=> rvalid_o && rdata_o[15:11] == QTR_EXP && rdata_o[10:4] == QTR_MANT_HI)
    else $error("start read lost fixed fields");
endmodule : threshold_regs
`default_nettype wire

// *** verif/pmbus_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side of the register port, strobes launched at falling edges
module pmbus_host_model (
  input wire logic clk_i, // system clock
  input wire logic [15:0] rdata_i, // read word
  input wire logic rvalid_i, // read word valid
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic [7:0] cmd_o, // command code
  output logic [15:0] wdata_o // write word
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // one write over one rising edge; released lines show inverted data
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk_i);
    wr_o = 1'b1;
    cmd_o = cmd;
    wdata_o = data;
    @(negedge clk_i);
    wr_o = 1'b0;
    cmd_o = ~cmd;
    wdata_o = ~data;
  endtask : write_word
  // one read; valid rises at the taking edge itself, half a cycle before, so it is
  // sampled at the following falling edge before the strobe is released
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                           output logic ok);
    @(negedge clk_i);
    rd_o = 1'b1;
    cmd_o = cmd;
    @(negedge clk_i);
    ok = rvalid_i;
    data = rdata_i;
    rd_o = 1'b0;
    cmd_o = ~cmd;
  endtask : read_word
endmodule : pmbus_host_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import threshold_pkg::*;
  logic clk_i, rst_i, ce_i, loop_half_i, clr_status_i, store_all_i;
  logic start_ok_i, out_on_i, vref_req_i, wr, rd, rvalid, cml, ivd, warn;
  logic alert, run, nvm_we, rd_ok;
  logic [7:0] cmd;
  logic [15:0] wdata, vin_code_i, vref_target_i, rdata, vref, rd_word;
  logic [15:0] nvm_start, nvm_stop;
  int errors, checked;
  threshold_regs threshold_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wr_i(wr), .rd_i(rd), .cmd_i(cmd), .wdata_i(wdata),
    .loop_half_i(loop_half_i), .clr_status_i(clr_status_i),
    .store_all_i(store_all_i), .vin_code_i(vin_code_i),
    .start_ok_i(start_ok_i), .out_on_i(out_on_i), .vref_req_i(vref_req_i),
    .vref_target_i(vref_target_i), .rdata_o(rdata), .rvalid_o(rvalid),
    .cml_o(cml), .ivd_o(ivd), .warn_o(warn), .alert_o(alert), .run_o(run),
    .vref_o(vref), .nvm_we_o(nvm_we), .nvm_start_o(nvm_start),
    .nvm_stop_o(nvm_stop));
  pmbus_host_model pmbus_host_model_inst (.clk_i(clk_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wdata));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    pmbus_host_model_inst.write_word(c, d);
  endtask : put
  task automatic get(input logic [7:0] c, input logic [15:0] exp);
    pmbus_host_model_inst.read_word(c, rd_word, rd_ok);
    check({15'h0000, rd_ok}, 16'h0001);
    check(rd_word, exp);
  endtask : get
  // cml, ivd, alert as three bits
  task automatic flags(input logic [2:0] exp);
    check({13'h0000, cml, ivd, alert}, {13'h0000, exp});
  endtask : flags
  task automatic clear;
    @(negedge clk_i);
    clr_status_i = 1'b1;
    @(negedge clk_i);
    clr_status_i = 1'b0;
  endtask : clear
  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : settle
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, far beyond the sequence length
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    loop_half_i = 1'b0;
    clr_status_i = 1'b0;
    store_all_i = 1'b0;
    start_ok_i = 1'b0;
    out_on_i = 1'b0;
    vref_req_i = 1'b0;
    vin_code_i = 16'h0000;
    vref_target_i = 16'h0000;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    settle(3);
    get(CMD_START, START_RST);
    get(CMD_STOP, STOP_RST);
    get(CMD_FLOOR, FLOOR_RST);
    $display("reset values test ended");
    // exponent -3, mantissa 41: 20.5 rounds up to 21
    put(CMD_START, 16'hE829);
    get(CMD_START, 16'hF015);
    put(CMD_START, 16'hF00F);
    flags(3'b111);
    get(CMD_START, 16'hF015);
    clear();
    put(CMD_START, 16'hF020);
    flags(3'b111);
    clear();
    put(CMD_START, 16'hF01F);
    get(CMD_START, 16'hF01F);
    put(CMD_START, 16'hF015);
    put(CMD_STOP, 16'hF00F);
    flags(3'b111);
    clear();
    put(CMD_STOP, 16'hF016);
    flags(3'b111);
    get(CMD_STOP, STOP_RST);
    clear();
    // exponent 0, mantissa 5: 20 counts, stored with fixed upper part
    put(CMD_STOP, 16'h0005);
    get(CMD_STOP, 16'hF014);
    flags(3'b000);
    put(CMD_START, 16'hF014);
    flags(3'b111);
    get(CMD_START, 16'hF015);
    clear();
    $display("threshold test ended");
    put(CMD_FLOOR, FLOOR_MAX_FULL);
    get(CMD_FLOOR, FLOOR_MAX_FULL);
    put(CMD_FLOOR, 16'h0301);
    flags(3'b111);
    clear();
    put(CMD_FLOOR, 16'h00B2);
    flags(3'b111);
    clear();
    loop_half_i = 1'b1;
    put(CMD_FLOOR, FLOOR_MAX_HALF);
    get(CMD_FLOOR, FLOOR_MAX_HALF);
    put(CMD_FLOOR, 16'h0165);
    flags(3'b111);
    clear();
    put(CMD_FLOOR, FLOOR_MIN_HALF);
    get(CMD_FLOOR, FLOOR_MIN_HALF);
    $display("floor test ended");
    // request below the floor while on, then one above it
    @(negedge clk_i);
    out_on_i = 1'b1;
    vref_target_i = 16'h0100;
    vref_req_i = 1'b1;
    @(negedge clk_i);
    vref_req_i = 1'b0;
    check(vref, FLOOR_MIN_HALF);
    check({14'h0000, warn, alert}, 16'h0003);
    clear();
    vref_target_i = 16'h0200;
    vref_req_i = 1'b1;
    @(negedge clk_i);
    vref_req_i = 1'b0;
    check(vref, 16'h0200);
    check({14'h0000, warn, alert}, 16'h0000);
    $display("reference test ended");
    // start 21, stop 20 quarter volts
    start_ok_i = 1'b1;
    vin_code_i = 16'h0014;
    settle(2);
    check({15'h0000, run}, 16'h0000);
    vin_code_i = 16'h0015;
    settle(2);
    check({15'h0000, run}, 16'h0001);
    vin_code_i = 16'h0014;
    settle(2);
    check({15'h0000, run}, 16'h0000);
    $display("run test ended");
    store_all_i = 1'b1;
    @(negedge clk_i);
    store_all_i = 1'b0;
    check({15'h0000, nvm_we}, 16'h0001);
    check(nvm_start, 16'hF015);
    check(nvm_stop, 16'hF014);
    $display("store test ended");
    // second reset with run low and the loop at one half
    rst_i = 1'b1;
    settle(2);
    rst_i = 1'b0;
    settle(3);
    get(CMD_FLOOR, FLOOR_MIN_HALF);
    get(CMD_START, START_RST);
    get(CMD_STOP, STOP_RST);
    check({15'h0000, run}, 16'h0001);
    $display("second reset test ended");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
